//--- rtl/mica_top.sv
// Dropped-frame counter and indirect MAC register access over APB.
`timescale 1ns/1ps
module mica_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        frame_dropped,
   output logic             csr_req,
   output logic             csr_read,
   output logic [7:0]       csr_index,
   output logic [31:0]      csr_wdata,
   input  wire logic        csr_ack,
   input  wire logic [31:0] csr_rdata,
   output logic             irq
);

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   logic        setup;
   logic        wr_en;
   logic        rd_en;
   logic        hit_drop;
   logic        hit_cmd;
   logic        hit_data;
   logic        hit_sts;
   logic        hit_msk;
   logic        mapped;

   assign setup    = psel & ~penable;
   assign wr_en    = psel & penable & pready & pwrite;
   assign rd_en    = psel & penable & pready & ~pwrite;
   assign hit_drop = (paddr == mica_pkg::DROP_COUNT_OFS);
   assign hit_cmd  = (paddr == mica_pkg::CSR_COMMAND_OFS);
   assign hit_data = (paddr == mica_pkg::CSR_DATA_OFS);
   assign hit_sts  = (paddr == mica_pkg::IRQ_STATUS_OFS);
   assign hit_msk  = (paddr == mica_pkg::IRQ_MASK_OFS);
   assign mapped   = hit_drop | hit_cmd | hit_data | hit_sts | hit_msk;

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [31:0]        tally_reg;
   logic [31:0]        tally_next;
   mica_pkg::mica_cmd_s cmd_reg;
   mica_pkg::mica_cmd_s cmd_next;
   logic [31:0]        wdata_reg;
   logic [31:0]        fetch_reg;
   logic [31:0]        sts_reg;
   logic [31:0]        sts_next;
   logic [31:0]        msk_reg;
   mica_pkg::mica_state_e state_reg;
   mica_pkg::mica_state_e state_next;
   logic               drop_s1;
   logic               drop_s2;
   logic               drop_s3;
   logic               drop_pulse;
   logic               half_cross;
   logic               start;
   logic               done;

   // The drop strobe comes from the MAC's domain, so it is synchronised
   // and edge detected; one frame drop is one rising edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drop_s1 <= 1'b0;
         drop_s2 <= 1'b0;
         drop_s3 <= 1'b0;
      end else begin
         drop_s1 <= frame_dropped;
         drop_s2 <= drop_s1;
         drop_s3 <= drop_s2;
      end
   end
   assign drop_pulse = drop_s2 & ~drop_s3;

   // clear on read
   // The clearing read takes away only what the setup cycle captured into
   // prdata, so drops counted between setup and access, or in the access
   // cycle itself, stay in the tally and no event is lost.
   assign tally_next = rd_en && hit_drop
                     ? tally_reg - prdata + {31'h0000_0000, drop_pulse}
                     : tally_reg + {31'h0000_0000, drop_pulse};
   assign half_cross = drop_pulse &&
                       (tally_reg == mica_pkg::HALF_BELOW) &&
                       !(rd_en && hit_drop);

   assign start = wr_en && hit_cmd && !cmd_reg.busy &&
                  pwdata[mica_pkg::BUSY_BIT];
   assign done  = (state_reg == mica_pkg::MICA_WAIT) && csr_ack;

   always_comb begin
      cmd_next = cmd_reg;
      if (wr_en && hit_cmd && !cmd_reg.busy) begin
         cmd_next.read  = pwdata[mica_pkg::DIR_BIT];
         cmd_next.index = pwdata[mica_pkg::INDEX_MSB:0];
         cmd_next.busy  = pwdata[mica_pkg::BUSY_BIT];
      end
      if (done) begin
         cmd_next.busy = 1'b0;
      end
   end

   // Status bits set by hardware win over a same-cycle write-one clear.
   assign sts_next = (sts_reg & ~(wr_en && hit_sts ? pwdata : 32'h0))
                   | (half_cross ? mica_pkg::IRQ_IMPL_MASK : 32'h0);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         mica_pkg::MICA_IDLE: begin
            if (start) begin
               state_next = mica_pkg::MICA_REQ;
            end
         end
         mica_pkg::MICA_REQ: begin
            state_next = mica_pkg::MICA_WAIT;
         end
         mica_pkg::MICA_WAIT: begin
            if (csr_ack) begin
               state_next = mica_pkg::MICA_IDLE;
            end
         end
         default: begin
            state_next = mica_pkg::MICA_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tally_reg <= mica_pkg::ZERO_WORD;
         cmd_reg   <= '0;
         sts_reg   <= mica_pkg::ZERO_WORD;
         msk_reg   <= mica_pkg::ZERO_WORD;
         state_reg <= mica_pkg::MICA_IDLE;
      end else begin
         tally_reg <= tally_next;
         cmd_reg   <= cmd_next;
         sts_reg   <= sts_next & mica_pkg::IRQ_IMPL_MASK;
         state_reg <= state_next;
         if (wr_en && hit_msk) begin
            msk_reg <= pwdata & mica_pkg::IRQ_IMPL_MASK;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdata_reg <= mica_pkg::ZERO_WORD;
         fetch_reg <= mica_pkg::ZERO_WORD;
      end else begin
         if (wr_en && hit_data && !cmd_reg.busy) begin
            wdata_reg <= pwdata;
         end
         if (done && cmd_reg.read) begin
            fetch_reg <= csr_rdata;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Internal register port
   // ----------------------------------------------------------------------
   // The request is held as a level until the MAC acknowledges it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         csr_req   <= 1'b0;
         csr_read  <= 1'b0;
         csr_index <= 8'h00;
         csr_wdata <= mica_pkg::ZERO_WORD;
      end else begin
         if (state_reg == mica_pkg::MICA_REQ) begin
            csr_req   <= 1'b1;
            csr_read  <= cmd_reg.read;
            csr_index <= cmd_reg.index;
            csr_wdata <= wdata_reg;
         end else if (done) begin
            csr_req   <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Read data and answer
   // ----------------------------------------------------------------------
   logic [31:0] cmd_word;
   logic [31:0] data_word;
   logic [31:0] rd_mux;

   assign cmd_word = {cmd_reg.busy, cmd_reg.read, 22'h00_0000,
                      cmd_reg.index};
   assign data_word = cmd_reg.read ? fetch_reg : wdata_reg;
   assign rd_mux = hit_drop ? tally_reg :
                   hit_cmd  ? cmd_word  :
                   hit_data ? data_word :
                   hit_sts  ? sts_reg   :
                   hit_msk  ? msk_reg   : mica_pkg::ZERO_WORD;

   // Zero wait states: pready rises in the access cycle after setup.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= mica_pkg::ZERO_WORD;
         irq     <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         prdata  <= setup && !pwrite ? rd_mux : mica_pkg::ZERO_WORD;
         irq     <= |(sts_next & msk_reg & mica_pkg::IRQ_IMPL_MASK);
      end
   end

endmodule

//--- pkg/mica_pkg.sv
// Package with register map, field layout and carrier types of the block.
package mica_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0]  DROP_COUNT_OFS  = 8'ha0;
   localparam logic [7:0]  CSR_COMMAND_OFS = 8'ha4;
   localparam logic [7:0]  CSR_DATA_OFS    = 8'ha8;
   localparam logic [7:0]  IRQ_STATUS_OFS  = 8'hb0;
   localparam logic [7:0]  IRQ_MASK_OFS    = 8'hb4;

   // ----------------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------------
   localparam int          BUSY_BIT        = 31;
   localparam int          DIR_BIT         = 30;
   localparam int          INDEX_MSB       = 7;
   localparam int          HALF_FLAG_BIT   = 23;
   localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
   localparam logic [31:0] HALF_POINT      = 32'h8000_0000;
   localparam logic [31:0] HALF_BELOW      = 32'h7fff_ffff;
   localparam logic [31:0] IRQ_IMPL_MASK   = 32'h0080_0000;

   // ----------------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic       busy;
      logic       read;
      logic [7:0] index;
   } mica_cmd_s;

   typedef struct packed {
      logic        req;
      logic        read;
      logic [7:0]  index;
      logic [31:0] wdata;
   } mica_csr_req_s;

   typedef enum logic [2:0] {
      MICA_IDLE = 3'b001,
      MICA_REQ  = 3'b010,
      MICA_WAIT = 3'b100
   } mica_state_e;

endpackage

//--- verification/mica_chk_sva.sv
// Checker on the ports of the register slice.
`timescale 1ns/1ps
module mica_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        csr_req,
   input wire logic        csr_read,
   input wire logic [7:0]  csr_index,
   input wire logic [31:0] csr_wdata,
   input wire logic        csr_ack,
   input wire logic        irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic acc = psel && penable && pready && pwrite;
   chk_req_held: assert property (csr_req && !csr_ack |=> csr_req)
      else $error("request dropped early");
   chk_req_steady: assert property (csr_req && !csr_ack |=>
      $stable(csr_index) && $stable(csr_wdata) && $stable(csr_read))
      else $error("request fields moved");
   chk_req_done: assert property (csr_req && csr_ack |=> !csr_req)
      else $error("request held after ack");
   chk_start_req: assert property (acc && paddr == 8'ha4 && pwdata[31]
      && !csr_req |-> ##2 csr_req && csr_index == $past(pwdata[7:0], 2)
      && csr_read == $past(pwdata[30], 2))
      else $error("indirect access not started");
   chk_ready_ans: assert property (psel && !penable |=> pready)
      else $error("no answer in access cycle");
   chk_ready_one: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_err_map: assert property (psel && penable && pready |-> pslverr ==
      !(paddr inside {8'ha0, 8'ha4, 8'ha8, 8'hb0, 8'hb4}))
      else $error("error response wrong");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   chk_irq_mask: assert property (acc && paddr == 8'hb4
      && !pwdata[23] |-> ##2 !irq)
      else $error("masked interrupt still high");
endmodule
bind mica_top mica_chk i_mica_chk (.*);

//--- verification/mica_mac_model.sv
// Behavioural model of the MAC internal register file.
`timescale 1ns/1ps
module mica_mac_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        csr_req,
   input  wire logic        csr_read,
   input  wire logic [7:0]  csr_index,
   input  wire logic [31:0] csr_wdata,
   input  wire logic [3:0]  lag,
   output logic             csr_ack,
   output logic [31:0]      csr_rdata
);
   logic [31:0] mem [256];
   logic [31:0] rd_q;
   logic [3:0]  cnt;
   // Between answers the data lines carry junk, never the old value.
   assign csr_rdata = csr_ack ? rd_q : ~rd_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         csr_ack <= 1'b0;
         cnt <= 4'h0;
         rd_q <= 32'h0;
      end else if (csr_ack || !csr_req) begin
         csr_ack <= 1'b0;
         cnt <= 4'h0;
      end else if (cnt == lag) begin
         csr_ack <= 1'b1;
         rd_q <= mem[csr_index];
         if (!csr_read) begin
            mem[csr_index] <= csr_wdata;
         end
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule

//--- verification/tb.sv
// Self-checking bench for the drop tally and indirect access.
`timescale 1ns/1ps
module tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        frame_dropped = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  lag = 4'h0;
   logic [31:0] prdata, csr_wdata, csr_rdata, rd, val;
   logic [7:0]  csr_index, idx;
   logic        pready, pslverr, csr_req, csr_read, csr_ack, irq, err;
   logic [31:0] exp_mem [logic [7:0]];
   int          miscompares = 0, total_checks = 0, cycles = 0, k;
   always #12.5 pclk = ~pclk;
   mica_top i_mica_top (.*);
   mica_mac_model i_mica_mac_model (.*);
   task automatic chk(input string what, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic wr, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
   endtask
   task automatic xfer(input logic rdn);
      int n;
      n = 0;
      lag <= 4'($urandom_range(0, 9));
      if (!rdn) begin
         apb(1'b1, 8'ha8, val);
         exp_mem[idx] = val;
      end
      apb(1'b1, 8'ha4, {1'b1, rdn, 22'h0, idx});
      apb(1'b1, 8'ha8, ~val);
      apb(1'b0, 8'ha4, 32'h0);
      chk("busy", 32'h1, {31'h0, rd[31]});
      while (rd[31] !== 1'b0 && n < 50) begin
         apb(1'b0, 8'ha4, 32'h0);
         n++;
      end
      chk("command", {1'b0, rdn, 22'h0, idx}, rd);
      apb(1'b0, 8'ha8, 32'h0);
      chk("data", rdn ? exp_mem[idx] : val, rd);
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles > 20000) begin
         miscompares++;
         final_report();
      end
   end
   initial begin
      void'($urandom(32'hf04c));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int a = 'ha0; a <= 'ha8; a += 4) begin
         apb(1'b0, 8'(a), 32'h0);
         chk("reset value", 32'h0, rd);
      end
      apb(1'b0, 8'hbc, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      for (int t = 0; t < 3; t++) begin
         k = $urandom_range(1, 6);
         psel <= 1'b0;
         penable <= 1'b0;
         repeat (k) begin
            frame_dropped <= 1'b1;
            repeat (3) @(posedge pclk);
            frame_dropped <= 1'b0;
            repeat (3) @(posedge pclk);
         end
         apb(1'b0, 8'ha0, 32'h0);
         chk("drop tally", 32'(k), rd);
      end
      apb(1'b0, 8'ha0, 32'h0);
      chk("tally cleared", 32'h0, rd);
      apb(1'b1, 8'hb4, 32'h0080_0000);
      apb(1'b0, 8'hb4, 32'h0);
      chk("irq mask", 32'h0080_0000, rd);
      apb(1'b1, 8'hb0, 32'h0080_0000);
      apb(1'b0, 8'hb0, 32'h0);
      chk("irq status", 32'h0, rd);
      apb(1'b1, 8'hb4, 32'h0);
      chk("irq line", 32'h0, {31'h0, irq});
      for (int t = 0; t < 6; t++) begin
         idx = 8'($urandom);
         val = $urandom;
         xfer(1'b0);
      end
      foreach (exp_mem[i]) begin
         idx = i;
         xfer(1'b1);
      end
      final_report();
   end
endmodule
